// ---- pcd_decoder.sv ----
// Function
// [RULE1] sync word is 31 sequence bits plus even parity; it sets word boundaries
// [RULE2] sync pattern is 0111 1100 1101 0010 0001 0101 1101 1000, bit 1 first
// [RULE3] first bit clear means address word, set means message word
// [RULE4] bits 2 to 21 form the information field
// [RULE5] address bits 20 and 21 select call type A, B, C or D
// [RULE6] bits 22 to 31 are BCH(31,21) check bits over bits 1 to 21
// [RULE7] bit 32 is even parity over bits 1 to 31
// [RULE8] address bits 2 to 19 compare with upper 18 call sign bits
// [RULE9] lowest 3 call sign bits are kept as frame identity
// [RULE10] idle word in any position carries no information
// [RULE11] idle pattern is 0111 1010 1000 1001 1100 0001 1001 0111
// [RULE12] idle word ends message reception
// [RULE13] preamble accepted with high time 25% to 75% of each cycle
// [RULE14] after sync, frame following bits into 32-bit words, first bit first
// [RULE15] sync or address accepted with at most 2 differing bits
// [RULE16] preamble seen on six-bit pattern 101010 or 010101
`timescale 1ns/100ps
`default_nettype none
`include "pcd_cfg.svh"

module pcd_decoder
    import pcd_pkg::*;
#(
    parameter int DUTY_CNT_W   = 16,
    parameter int DUTY_CYCLES  = 3
)
(
    // clock and reset
    input  wire logic  ref_clk,
    input  wire logic  sys_rst,
    // received stream
    input  wire pcd_bit_s  rx_bit,
    input  wire logic  sig_level,
    // identity load
    input  wire pcd_id_s   id_in,
    // decoded results
    output pcd_word_s  word_out,
    output logic       sync_det,
    output logic       aligned,
    output logic       in_message,
    output logic       preamble_det,
    output logic [2:0] frame_id
);

    pcd_frm_s st;
    pcd_frm_s nx;
    logic     duty_ok;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // number of differing bits between two words
    function automatic logic [5:0] pcd_dist(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] d;
        logic [5:0]  n;
        d = a ^ b;
        n = 6'h00;
        for (int i = 0; i < 32; i++)
            n = n + {5'h00, d[i]};
        pcd_dist = n;
    endfunction

    // remainder of bits 1..31 over the generator; zero for a clean word
    function automatic logic [9:0] pcd_syndrome(input logic [31:0] w);
        logic [10:0] r;
        r = 11'h000;
        for (int i = 31; i >= 1; i--)
        begin
            r = {r[9:0], w[i]};
            if (r[10])
                r = r ^ `PCD_BCH_POLY;
        end
        pcd_syndrome = r[9:0];
    endfunction

    // classify and split one aligned code word
    function automatic pcd_word_s pcd_decode(input logic [31:0] w, input logic [17:0] call_hi);
        pcd_word_s o;
        o            = '0;
        o.valid      = 1'b1;
        o.info       = w[`PCD_INFO_HI:`PCD_INFO_LO];                          // RULE4
        o.call       = pcd_call_e'(w[`PCD_FUNC_HI:`PCD_FUNC_LO]);             // RULE5
        o.bch_ok     = (pcd_syndrome(w) == 10'h000);                          // RULE6
        o.parity_ok  = ~(^w);                                                 // RULE7
        if (pcd_dist(w, `PCD_SYNC_WORD) <= `PCD_MAX_ERRS)                     // RULE15
            o.kind = kind_sync;                                               // RULE2
        else if (w == `PCD_IDLE_WORD)                                         // RULE11
        begin
            o.kind = kind_idle;
            o.info = 20'h00000;                                               // RULE10
        end
        else if (!w[`PCD_TYPE_BIT])                                           // RULE3
        begin
            o.kind       = kind_addr;
            o.addr_match = (pcd_dist({14'h0000, w[`PCD_ADDR_HI:`PCD_ADDR_LO]},
                                     {14'h0000, call_hi}) <= `PCD_MAX_ERRS);  // RULE8 RULE15
        end
        else
            o.kind = kind_msg;                                                // RULE3
        pcd_decode = o;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // raw-level preamble detector

    pcd_duty #(
        .CNT_W       (DUTY_CNT_W),
        .GOOD_CYCLES (DUTY_CYCLES)
    ) u_duty (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .sig_level (sig_level),
        .duty_ok   (duty_ok)
    );

    ////////////////////////////////////////////////////////////////////////
    // framer next state
    always_comb
    begin
        logic [31:0] shifted;
        pcd_word_s   w;
        shifted       = {st.sr[30:0], rx_bit.data};
        w             = pcd_decode(shifted, st.call_hi);
        nx            = st;
        nx.word.valid = 1'b0;
        nx.sync_pulse = 1'b0;

        // identity store: upper part compared, lower part kept
        if (id_in.load)
        begin
            nx.call_hi  = id_in.call_sign[`PCD_CALL_BITS-1:`PCD_FRAME_ID_BITS];  // RULE8
            nx.frame_id = id_in.call_sign[`PCD_FRAME_ID_BITS-1:0];               // RULE9
        end

        if (rx_bit.valid)
        begin
            nx.sr = shifted;                                                  // RULE14
            // six-bit alternation only counts while hunting for sync
            nx.pattern_hit = !st.aligned &&
                             (shifted[5:0] == `PCD_PRE_PAT_A ||
                              shifted[5:0] == `PCD_PRE_PAT_B);                // RULE16
            if (!st.aligned)
            begin
                // sliding search on every bit until the sync word turns up
                if (w.kind == kind_sync)                                      // RULE1 RULE15
                begin
                    nx.aligned    = 1'b1;
                    nx.bit_cnt    = 5'h00;
                    nx.word_idx   = 5'h00;
                    nx.word       = w;
                    nx.sync_pulse = 1'b1;
                end
            end
            else if (st.bit_cnt == 5'h1f)
            begin
                // a whole word has arrived on this bit
                nx.bit_cnt = 5'h00;                                           // RULE14
                nx.word    = w;
                if (w.kind == kind_sync)
                begin
                    nx.sync_pulse = 1'b1;
                    nx.word_idx   = 5'h00;                                    // RULE1
                end
                else
                begin
                    nx.word_idx = st.word_idx + 5'h01;
                    // a missed sync slot drops lock unless a message runs
                    if (st.word_idx == `PCD_BATCH_WORDS && !st.in_message)
                        nx.aligned = 1'b0;
                end
                if (w.kind == kind_idle)
                    nx.in_message = 1'b0;                                     // RULE12
                else if (w.kind == kind_addr)
                    nx.in_message = w.addr_match;
            end
            else
                nx.bit_cnt = st.bit_cnt + 5'h01;                              // RULE14
        end
    end

    // single state register for the framer
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= nx;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops except the preamble merge
    assign word_out     = st.word;
    assign sync_det     = st.sync_pulse;
    assign aligned      = st.aligned;
    assign in_message   = st.in_message;
    assign frame_id     = st.frame_id;                                        // RULE9
    // either detector suffices, but only while unlocked
    assign preamble_det = !st.aligned && (st.pattern_hit || duty_ok);        // RULE13 RULE16

endmodule // pcd_decoder

`default_nettype wire

// ---- pcd_cfg.svh ----
`ifndef PCD_CFG_SVH
`define PCD_CFG_SVH

// word geometry, bit 1 of the air order sits in word[31]
`define PCD_WORD_BITS      32
`define PCD_TYPE_BIT       31
`define PCD_INFO_HI        30
`define PCD_INFO_LO        11
`define PCD_ADDR_HI        30
`define PCD_ADDR_LO        13
`define PCD_FUNC_HI        12
`define PCD_FUNC_LO        11
`define PCD_CHK_HI         10
`define PCD_CHK_LO         1
`define PCD_PAR_BIT        0

// fixed code words, bit 1 first
`define PCD_SYNC_WORD      32'h7cd215d8
`define PCD_IDLE_WORD      32'h7a89c197

// block code generator x^10+x^9+x^8+x^6+x^5+x^3+1
`define PCD_BCH_POLY       11'h769
`define PCD_BCH_CHK_BITS   10

// error tolerance for sync and address comparison
`define PCD_MAX_ERRS       6'h02

// call sign split
`define PCD_CALL_BITS      21
`define PCD_FRAME_ID_BITS  3

// six-bit preamble patterns
`define PCD_PRE_PAT_A      6'h2a
`define PCD_PRE_PAT_B      6'h15

// duty factor window in percent
`define PCD_DUTY_MIN_PCT   25
`define PCD_DUTY_MAX_PCT   75

// code words between two sync slots
`define PCD_BATCH_WORDS    5'h10

`endif

// ---- pcd_pkg.sv ----
package pcd_pkg;

    typedef enum logic [1:0] {kind_sync, kind_idle, kind_addr, kind_msg} pcd_kind_e;
    typedef enum logic [1:0] {call_a, call_b, call_c, call_d} pcd_call_e;

    // one received bit from the front end
    typedef struct packed {
        logic valid;
        logic data;
    } pcd_bit_s;

    // one classified code word
    typedef struct packed {
        logic        valid;
        pcd_kind_e   kind;
        logic [19:0] info;
        pcd_call_e   call;
        logic        bch_ok;
        logic        parity_ok;
        logic        addr_match;
    } pcd_word_s;

    // identity load from the host side
    typedef struct packed {
        logic        load;
        logic [20:0] call_sign;
    } pcd_id_s;

    // framer state
    typedef struct packed {
        logic [31:0] sr;
        logic [4:0]  bit_cnt;
        logic [4:0]  word_idx;
        logic        aligned;
        logic        in_message;
        logic        sync_pulse;
        logic        pattern_hit;
        logic [17:0] call_hi;
        logic [2:0]  frame_id;
        pcd_word_s   word;
    } pcd_frm_s;

    // duty factor detector state
    typedef struct packed {
        logic        prev;
        logic [15:0] high_cnt;
        logic [15:0] total_cnt;
        logic [3:0]  good_cnt;
    } pcd_duty_s;

endpackage

// ---- pcd_duty.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pcd_cfg.svh"

module pcd_duty
    import pcd_pkg::*;
#(
    parameter int CNT_W      = 16,
    parameter int GOOD_CYCLES = 3
)
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // raw received level
    input  wire logic sig_level,
    // accepted preamble alternation
    output logic      duty_ok
);

    pcd_duty_s st;
    pcd_duty_s nx;

    // true when the high share of a cycle lies in the duty window
    function automatic logic in_window(input logic [15:0] hi, input logic [15:0] tot);
        logic [31:0] h;
        logic [31:0] t;
        h = {16'h0000, hi} * 32'd100;
        t = {16'h0000, tot};
        in_window = (h >= t * `PCD_DUTY_MIN_PCT) && (h <= t * `PCD_DUTY_MAX_PCT);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // one cycle is measured rising edge to rising edge
    always_comb
    begin
        nx      = st;
        nx.prev = sig_level;
        if (sig_level && !st.prev)
        begin
            if (st.total_cnt != 16'h0000 && in_window(st.high_cnt, st.total_cnt)) // RULE13
                nx.good_cnt = (st.good_cnt == 4'hf) ? st.good_cnt : st.good_cnt + 4'h1;
            else
                nx.good_cnt = 4'h0;
            nx.high_cnt  = 16'h0001;
            nx.total_cnt = 16'h0001;
        end
        else if (st.total_cnt == {CNT_W{1'b1}})
        begin
            // a stuck level is no alternation, so start over
            nx.good_cnt  = 4'h0;
            nx.high_cnt  = 16'h0000;
            nx.total_cnt = 16'h0000;
        end
        else if (st.total_cnt != 16'h0000)
        begin
            nx.total_cnt = st.total_cnt + 16'h0001;
            nx.high_cnt  = st.high_cnt + {15'h0000, sig_level};
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= nx;
    end

    assign duty_ok = (st.good_cnt >= 4'(GOOD_CYCLES)); // RULE13

endmodule // pcd_duty

`default_nettype wire

// ---- pcd_decoder_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcd_decoder_asserts
    import pcd_pkg::*;
(
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    // watched ports
    input wire pcd_id_s    id_in,
    input wire pcd_word_s  word_out,
    input wire logic       sync_det,
    input wire logic       aligned,
    input wire logic       in_message,
    input wire logic       preamble_det,
    input wire logic [2:0] frame_id
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire logic      wv = word_out.valid;
    wire pcd_kind_e wk = word_out.kind;
    ////////////////////////////////////////
    property p_sync; sync_det |-> wv && wk == kind_sync && aligned; endproperty
    property p_sync_src; wv && wk == kind_sync |-> sync_det; endproperty
    property p_call; wv && wk == kind_addr |-> word_out.call == word_out.info[1:0]; endproperty
    property p_idle; wv && wk == kind_idle |-> word_out.info == 20'h0 && !word_out.addr_match; endproperty
    property p_idle_end; wv && wk == kind_idle |=> !in_message; endproperty
    property p_match; wv && word_out.addr_match |-> wk == kind_addr ##1 in_message; endproperty
    property p_fid; id_in.load |=> frame_id == $past(id_in.call_sign[2:0]); endproperty
    // a word needs 32 taken bits, so two results never come close together
    property p_gap; wv |=> !wv [*8]; endproperty
    property p_pre; aligned |-> !preamble_det; endproperty
    a_sync: assert property (p_sync) else $error("sync pulse without sync word");
    a_sync_src: assert property (p_sync_src) else $error("sync word without pulse");
    a_call: assert property (p_call) else $error("call type wrong");
    a_idle: assert property (p_idle) else $error("idle carries data");
    a_idle_end: assert property (p_idle_end) else $error("idle left message on");
    a_match: assert property (p_match) else $error("match did not open message");
    a_fid: assert property (p_fid) else $error("frame id not stored");
    a_gap: assert property (p_gap) else $error("word results too close");
    a_pre: assert property (p_pre) else $error("preamble while aligned");
    c_sync: cover property (sync_det);
    c_match: cover property (wv && word_out.addr_match);
    c_pre: cover property (preamble_det);
endmodule // pcd_decoder_asserts
`default_nettype wire

// ---- pcd_radio.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcd_radio
    import pcd_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // front end outputs
    output pcd_bit_s rx_bit,
    output logic     sig_level
);
    // quiet line at start
    initial
    begin
        rx_bit = '0;
        sig_level = 1'b0;
    end
    ////////////////////////////////////////
    // first bit first; a released data line shows the inverse of the last bit
    task automatic send_bits(input logic [31:0] w, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            @(posedge ref_clk);
            rx_bit <= '{1'b1, w[i]};
        end
        @(posedge ref_clk);
        rx_bit <= '{1'b0, ~w[0]};
    endtask
    // square wave of hi clocks high and lo clocks low
    task automatic send_duty(input int hi, input int lo, input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            sig_level <= 1'b1;
            repeat (hi) @(posedge ref_clk);
            sig_level <= 1'b0;
            repeat (lo - 1) @(posedge ref_clk);
        end
    endtask
endmodule // pcd_radio
`default_nettype wire

// ---- test_paging_codeword_decoder.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pcd_cfg.svh"
`define CHECK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module test_paging_codeword_decoder
    import pcd_pkg::*;
;
    logic       ref_clk = 1'b0;
    logic       sys_rst = 1'b1;
    pcd_id_s    id_in = '0;
    pcd_bit_s   rx_bit;
    pcd_word_s  word_out, last_w;
    logic       sig_level, sync_det, aligned, in_message, preamble_det;
    logic       got = 1'b0;
    logic       sync_seen = 1'b0;
    logic [2:0] frame_id;
    int         bad_count = 0, n_compared = 0, cycles = 0;
    localparam logic [17:0] ADDR = 18'h2b3c5;
    always #12.5 ref_clk = ~ref_clk;
    pcd_decoder #(.DUTY_CNT_W(16), .DUTY_CYCLES(2)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .rx_bit(rx_bit),
        .sig_level(sig_level), .id_in(id_in), .word_out(word_out), .sync_det(sync_det), .aligned(aligned),
        .in_message(in_message), .preamble_det(preamble_det), .frame_id(frame_id));
    pcd_radio radio (.ref_clk(ref_clk), .rx_bit(rx_bit), .sig_level(sig_level));
    ////////////////////////////////////////
    // catch each one-cycle result; the cycle ceiling cuts a hang short
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (word_out.valid === 1'b1)
        begin
            last_w <= word_out;
            got <= 1'b1;
        end
        if (sync_det === 1'b1)
            sync_seen <= 1'b1;
        if (cycles > 6000)
        begin
            bad_count++;
            final_report();
        end
    end
    // code word from bits 1..21: check bits by long division, then even parity
    function automatic logic [31:0] enc(input logic [20:0] d);
        logic [30:0] v;
        v = {d, 10'h0};
        for (int i = 30; i >= 10; i--)
            if (v[i])
                v[i -: 11] = v[i -: 11] ^ `PCD_BCH_POLY;
        return {d, v[9:0], ^{d, v[9:0]}};
    endfunction
    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
    endtask
    // okm holds expected check ok, parity ok and address match
    task automatic rx_word(input logic [31:0] w, input pcd_kind_e k, input logic [2:0] okm);
        got = 1'b0;
        sync_seen = 1'b0;
        radio.send_bits(w, 32);
        repeat (4) @(posedge ref_clk);
        `CHECK(got, 1'b1)
        `CHECK(sync_seen, k == kind_sync)
        `CHECK(last_w.kind, k)
        if (k != kind_sync)
        begin
            `CHECK(last_w.info, (k == kind_idle) ? 20'h0 : w[30:11])
            `CHECK({last_w.bch_ok, last_w.parity_ok}, okm[2:1])
        end
        if (k == kind_addr)
        begin
            `CHECK(last_w.call, w[12:11])
            `CHECK(last_w.addr_match, okm[0])
        end
    endtask
    // duty window edges at 25 and 75 percent; six cycles at 12.5 percent in between must drop detection
    task automatic t_duty();
        radio.send_duty(2, 6, 6);
        `CHECK(preamble_det, 1'b1)
        radio.send_duty(1, 7, 6);
        `CHECK(preamble_det, 1'b0)
        radio.send_duty(6, 2, 6);
        `CHECK(preamble_det, 1'b1)
    endtask
    // both six-bit patterns from a clean start
    task automatic t_pattern(input logic [5:0] p);
        do_reset();
        `CHECK(preamble_det, 1'b0)
        radio.send_bits({26'h0, p}, 6);
        // the hit registers on the edge that takes the last bit, so look one edge later
        @(posedge ref_clk);
        `CHECK(preamble_det, 1'b1)
    endtask
    task automatic t_frame();
        @(posedge ref_clk);
        id_in <= '{1'b1, {ADDR, 3'h5}};
        @(posedge ref_clk);
        id_in.load <= 1'b0;
        @(posedge ref_clk);
        `CHECK(frame_id, 3'h5)
        rx_word(`PCD_SYNC_WORD ^ 32'h80000001, kind_sync, 3'h0);
        `CHECK(aligned, 1'b1)
        for (int c = 0; c < 4; c++)
            rx_word(enc({1'b0, ADDR, 2'(c)}) ^ ((c == 3) ? 32'h30000000 : 32'h0), kind_addr,
                (c == 3) ? 3'h3 : 3'h7);
        `CHECK(in_message, 1'b1)
        rx_word(enc({1'b1, 20'h5a5a5}) ^ 32'h2, kind_msg, 3'h0);
        rx_word(enc({1'b1, 20'h0f00f}) ^ 32'h1, kind_msg, 3'h4);
        rx_word(`PCD_IDLE_WORD, kind_idle, 3'h6);
        `CHECK(in_message, 1'b0)
        rx_word(enc({1'b0, ADDR, 2'h1}) ^ 32'h70000000, kind_addr, 3'h0);
        `CHECK(in_message, 1'b0)
    endtask
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // main sequence
    initial
    begin
        do_reset();
        t_duty();
        t_pattern(`PCD_PRE_PAT_A);
        t_pattern(`PCD_PRE_PAT_B);
        t_frame();
        final_report();
    end
endmodule // test_paging_codeword_decoder
bind pcd_decoder pcd_decoder_asserts chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .id_in(id_in), .word_out(word_out),
    .sync_det(sync_det), .aligned(aligned), .in_message(in_message), .preamble_det(preamble_det), .frame_id(frame_id));
`default_nettype wire
